/* rtl/dlpsc_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef DLPSC_REGS_SVH
`define DLPSC_REGS_SVH
`define DLPSC_ADDR_W 4
`define DLPSC_OFF_SRCFG 4'h0
`define DLPSC_OFF_TERMCFG 4'h1
`define DLPSC_OFF_BANKS 4'h2
`define DLPSC_OFF_STATUS 4'h3
`define DLPSC_OFF_CTRL 4'h4
`define DLPSC_SR_RANGE_LSB 6
`define DLPSC_SR_RANGE_MSB 7
`define DLPSC_TERM_BUF_BIT 5
`define DLPSC_PARK_LSB 6
`define DLPSC_PARK_MSB 8
`define DLPSC_NOM_LSB 0
`define DLPSC_NOM_MSB 2
`define DLPSC_SRCFG_RST 16'h0000
`define DLPSC_TERMCFG_RST 16'h0000
`define DLPSC_CTRL_RST 16'h0000
`define DLPSC_CLK_NS 50
`define DLPSC_GUARD_NS 200
`define DLPSC_GUARD_CYC ((`DLPSC_GUARD_NS + `DLPSC_CLK_NS - 1) / `DLPSC_CLK_NS)
`endif

/* rtl/dlpsc_pkg.sv */
// Types shared by the low-power state control block
package dlpsc_pkg;
	typedef enum logic [1:0] {
		DLPSC_SR_NORMAL,
		DLPSC_SR_REDUCED,
		DLPSC_SR_EXTENDED,
		DLPSC_SR_AUTO
	} dlpsc_sr_mode_t;
	typedef enum logic [2:0] {
		DLPSC_RATE_NORMAL,
		DLPSC_RATE_REDUCED,
		DLPSC_RATE_HIGH,
		DLPSC_RATE_AUTO_LOW,
		DLPSC_RATE_AUTO_HIGH
	} dlpsc_rate_t;
endpackage

/* rtl/dlpsc_sync.sv */
// Two flip-flop synchroniser for pins and the sampled link clock
module dlpsc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;
	always_comb begin
		meta_next = d;
		q_next = meta_reg;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			q_reg <= q_next;
		end
	end
	assign q = q_reg;
endmodule // dlpsc_sync

/* rtl/dlpsc_rate.sv */
// Self-refresh rate selection from the range field and temperature
module dlpsc_rate (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Configuration and sensor
	input wire logic [1:0] range,
	input wire logic temp_hot,
	// Result
	output dlpsc_pkg::dlpsc_rate_t rate,
	output logic [6:0] temp_limit
);
	dlpsc_pkg::dlpsc_rate_t rate_reg;
	dlpsc_pkg::dlpsc_rate_t rate_next;
	logic [6:0] lim_reg;
	logic [6:0] lim_next;
	always_comb begin
		rate_next = dlpsc_pkg::DLPSC_RATE_NORMAL;
		lim_next = 7'h55;
		case (dlpsc_pkg::dlpsc_sr_mode_t'(range))
		dlpsc_pkg::DLPSC_SR_NORMAL: begin
			rate_next = dlpsc_pkg::DLPSC_RATE_NORMAL;
			lim_next = 7'h55;
		end
		dlpsc_pkg::DLPSC_SR_REDUCED: begin
			rate_next = dlpsc_pkg::DLPSC_RATE_REDUCED;
			lim_next = 7'h2D;
		end
		dlpsc_pkg::DLPSC_SR_EXTENDED: begin
			rate_next = dlpsc_pkg::DLPSC_RATE_HIGH;
			lim_next = 7'h5F;
		end
		dlpsc_pkg::DLPSC_SR_AUTO: begin
			// Rate follows temperature
			rate_next = temp_hot ? dlpsc_pkg::DLPSC_RATE_AUTO_HIGH
				: dlpsc_pkg::DLPSC_RATE_AUTO_LOW;
			lim_next = 7'h5F;
		end
		default: begin
			rate_next = dlpsc_pkg::DLPSC_RATE_NORMAL;
		end
		endcase
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rate_reg <= dlpsc_pkg::DLPSC_RATE_NORMAL;
			lim_reg <= 7'h55;
		end else begin
			rate_reg <= rate_next;
			lim_reg <= lim_next;
		end
	end
	assign rate = rate_reg;
	assign temp_limit = lim_reg;
	a_auto_rate: assert property (@(posedge clk) disable iff (!arst_n)
		range == 2'b11 |=> rate inside {dlpsc_pkg::DLPSC_RATE_AUTO_LOW,
		dlpsc_pkg::DLPSC_RATE_AUTO_HIGH})
		else $error("auto range did not pick auto rate");
	a_normal_rate: assert property (@(posedge clk) disable iff (!arst_n)
		range == 2'b00 |=> rate == dlpsc_pkg::DLPSC_RATE_NORMAL
		&& temp_limit == 7'h55)
		else $error("normal range wrong rate");
	a_reduced_rate: assert property (@(posedge clk) disable iff (!arst_n)
		range == 2'b01 |=> temp_limit == 7'h2D)
		else $error("reduced range wrong limit");
	a_high_rate: assert property (@(posedge clk) disable iff (!arst_n)
		range == 2'b10 |=> rate == dlpsc_pkg::DLPSC_RATE_HIGH)
		else $error("extended range wrong rate");
endmodule // dlpsc_rate

/* rtl/dlpsc_lp_ctrl.sv */
// Power-down and self-refresh state control of the memory device
`include "dlpsc_regs.svh"
// Contract
// - Both range bits set selects auto self-refresh; rate tracks temperature.
// - Range 00 gives normal fixed rate, valid to 85 degrees.
// - Range 01 gives reduced rate, valid to 45 degrees.
// - Range 10 gives high fixed rate, valid to 95 degrees.
// - CKE low with deselect enters power-down.
// - Closed banks give precharge power-down, any open gives active.
// - Power-down disables buffers except clock, CKE and reset.
// - Termination-buffer bit keeps or disables the ODT buffer.
// - Park termination stays applied during power-down when enabled.
// - Receivers turn off only after the CKE deselect guard time; self-refresh entry turns them off with no guard.
// - Reset during power-down leaves it and resets at once.
// - CKE high with deselect exits power-down.
module dlpsc_lp_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire logic [`DLPSC_ADDR_W-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Memory link pins
	input wire logic link_ck,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic odt,
	// Temperature sensor
	input wire logic temp_hot,
	// Power state outputs
	output logic pd_active,
	output logic pd_precharge,
	output logic self_refresh,
	output logic cmd_rx_en,
	output logic io_buf_en,
	output logic odt_buf_en,
	output logic nom_term_on,
	output logic park_term_on,
	output logic [2:0] sr_rate
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_GUARD,
		ST_PD,
		ST_SR
	} dlpsc_state_t;

	// Register-only decoding used in more than one place
	function automatic logic hit(input logic [`DLPSC_ADDR_W-1:0] a,
		input logic [`DLPSC_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	logic ck_s, cke_s, cs_n_s, odt_s, hot_s;
	dlpsc_sync #(.W(5)) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d({link_ck, cke, cs_n, odt, temp_hot}),
		.q({ck_s, cke_s, cs_n_s, odt_s, hot_s})
	);

	logic [15:0] srcfg_reg, srcfg_next;
	logic [15:0] term_reg, term_next;
	logic [7:0] banks_reg, banks_next;
	logic [15:0] ctrl_reg, ctrl_next;
	logic [15:0] rdata_reg, rdata_next;
	logic ck_d_reg, ck_d_next;
	dlpsc_state_t st_reg, st_next;
	logic [7:0] guard_reg, guard_next;
	logic pd_act_reg, pd_act_next;
	logic pd_pre_reg, pd_pre_next;
	logic sr_reg, sr_next;
	logic rx_reg, rx_next;
	logic io_reg, io_next;
	logic odtb_reg, odtb_next;
	logic nom_reg, nom_next;
	logic park_reg, park_next;
	logic ck_rise;
	logic deselect;
	logic [1:0] range;
	dlpsc_pkg::dlpsc_rate_t rate;
	logic [6:0] temp_limit;

	assign ck_rise = ck_s && !ck_d_reg;
	assign deselect = cs_n_s;
	assign range = srcfg_reg[`DLPSC_SR_RANGE_MSB:`DLPSC_SR_RANGE_LSB];

	dlpsc_rate u_rate (
		.clk(clk),
		.arst_n(arst_n),
		.range(range),
		.temp_hot(hot_s),
		.rate(rate),
		.temp_limit(temp_limit)
	);

	// Register file
	always_comb begin
		srcfg_next = srcfg_reg;
		term_next = term_reg;
		banks_next = banks_reg;
		ctrl_next = ctrl_reg;
		rdata_next = 16'h0000;
		if (reg_wr) begin
			if (hit(reg_addr, `DLPSC_OFF_SRCFG) && st_reg != ST_SR)
				srcfg_next = reg_wdata;
			if (hit(reg_addr, `DLPSC_OFF_TERMCFG))
				term_next = reg_wdata;
			if (hit(reg_addr, `DLPSC_OFF_BANKS))
				banks_next = reg_wdata[7:0];
			if (hit(reg_addr, `DLPSC_OFF_CTRL))
				ctrl_next = reg_wdata;
		end
		if (reg_rd) begin
			case (reg_addr)
			`DLPSC_OFF_SRCFG: rdata_next = srcfg_reg;
			`DLPSC_OFF_TERMCFG: rdata_next = term_reg;
			`DLPSC_OFF_BANKS: rdata_next = {8'h00, banks_reg};
			`DLPSC_OFF_STATUS: rdata_next = {2'b00, temp_limit,
				rate, sr_reg, pd_pre_reg, pd_act_reg, rx_reg};
			`DLPSC_OFF_CTRL: rdata_next = ctrl_reg;
			default: rdata_next = 16'h0000;
			endcase
		end
	end

	// Link state machine, advanced on sampled link clock rising edges
	always_comb begin
		st_next = st_reg;
		guard_next = guard_reg;
		pd_act_next = pd_act_reg;
		pd_pre_next = pd_pre_reg;
		sr_next = sr_reg;
		if (ck_rise) begin
			case (st_reg)
			ST_IDLE: begin
				if (!cke_s && deselect) begin
					st_next = ST_GUARD;
					guard_next = 8'(`DLPSC_GUARD_CYC);
				end else if (!cke_s && ctrl_reg[0]) begin
					st_next = ST_SR;
				end
			end
			ST_GUARD: begin
				// Receivers stay on while the guard runs
				if (cke_s && deselect) begin
					st_next = ST_IDLE;
				end else if (guard_reg <= 8'h01) begin
					st_next = ST_PD;
					guard_next = 8'h00;
				end else begin
					guard_next = guard_reg - 8'h01;
				end
			end
			ST_PD: begin
				if (cke_s && deselect)
					st_next = ST_IDLE;
			end
			ST_SR: begin
				// Plain NOP or deselect both count as exit
				if (cke_s)
					st_next = ST_IDLE;
			end
			default: st_next = ST_IDLE;
			endcase
		end
		pd_act_next = (st_next == ST_GUARD || st_next == ST_PD)
			&& (banks_reg != 8'h00);
		pd_pre_next = (st_next == ST_GUARD || st_next == ST_PD)
			&& (banks_reg == 8'h00);
		sr_next = (st_next == ST_SR);
	end

	// Buffer and termination control
	always_comb begin
		rx_next = !(st_next == ST_PD || st_next == ST_SR);
		io_next = !(st_next == ST_PD || st_next == ST_SR);
		odtb_next = 1'b1;
		nom_next = term_reg[`DLPSC_NOM_MSB:`DLPSC_NOM_LSB] != 3'b000
			&& odt_s;
		park_next = term_reg[`DLPSC_PARK_MSB:`DLPSC_PARK_LSB] != 3'b000;
		if (st_next == ST_PD) begin
			odtb_next = !term_reg[`DLPSC_TERM_BUF_BIT];
			if (term_reg[`DLPSC_TERM_BUF_BIT])
				nom_next = 1'b0;
		end
		if (st_next == ST_SR) begin
			odtb_next = 1'b0;
			nom_next = 1'b0;
			park_next = 1'b0;
		end
		// Park stays on in power-down when enabled
		if (st_next == ST_PD)
			park_next = term_reg[`DLPSC_PARK_MSB:`DLPSC_PARK_LSB]
				!= 3'b000;
	end

	// Reset drops every state at once, power-down included
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			srcfg_reg <= `DLPSC_SRCFG_RST;
			term_reg <= `DLPSC_TERMCFG_RST;
			banks_reg <= 8'h00;
			ctrl_reg <= `DLPSC_CTRL_RST;
			rdata_reg <= 16'h0000;
			ck_d_reg <= 1'b0;
			st_reg <= ST_IDLE;
			guard_reg <= 8'h00;
			pd_act_reg <= 1'b0;
			pd_pre_reg <= 1'b0;
			sr_reg <= 1'b0;
			rx_reg <= 1'b1;
			io_reg <= 1'b1;
			odtb_reg <= 1'b1;
			nom_reg <= 1'b0;
			park_reg <= 1'b0;
		end else begin
			srcfg_reg <= srcfg_next;
			term_reg <= term_next;
			banks_reg <= banks_next;
			ctrl_reg <= ctrl_next;
			rdata_reg <= rdata_next;
			ck_d_reg <= ck_s;
			st_reg <= st_next;
			guard_reg <= guard_next;
			pd_act_reg <= pd_act_next;
			pd_pre_reg <= pd_pre_next;
			sr_reg <= sr_next;
			rx_reg <= rx_next;
			io_reg <= io_next;
			odtb_reg <= odtb_next;
			nom_reg <= nom_next;
			park_reg <= park_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign pd_active = pd_act_reg;
	assign pd_precharge = pd_pre_reg;
	assign self_refresh = sr_reg;
	assign cmd_rx_en = rx_reg;
	assign io_buf_en = io_reg;
	assign odt_buf_en = odtb_reg;
	assign nom_term_on = nom_reg;
	assign park_term_on = park_reg;
	assign sr_rate = rate;

	a_pd_entry: assert property (@(posedge clk) disable iff (!arst_n)
		st_reg == ST_IDLE && ck_rise && !cke_s && cs_n_s
		|=> st_reg == ST_GUARD)
		else $error("power-down entry missed");
	a_pd_exit: assert property (@(posedge clk) disable iff (!arst_n)
		st_reg == ST_PD && ck_rise && cke_s && cs_n_s
		|=> st_reg == ST_IDLE ##1 rx_reg)
		else $error("power-down exit missed");
	a_pd_kind: assert property (@(posedge clk) disable iff (!arst_n)
		st_reg == ST_PD |-> pd_act_reg == (banks_reg != 8'h00)
		|| $changed(banks_reg))
		else $error("power-down kind wrong");
	a_buf_off: assert property (@(posedge clk) disable iff (!arst_n)
		st_reg == ST_PD |-> !io_reg)
		else $error("buffers on in power-down");
	a_odt_buf: assert property (@(posedge clk) disable iff (!arst_n)
		st_reg == ST_PD && !$changed(term_reg)
		|-> odtb_reg == !term_reg[`DLPSC_TERM_BUF_BIT])
		else $error("odt buffer wrong in power-down");
	a_park_kept: assert property (@(posedge clk) disable iff (!arst_n)
		st_reg == ST_PD && $stable(term_reg)
		&& term_reg[8:6] != 3'b000 |-> park_reg)
		else $error("park termination dropped");
	a_guard_rx: assert property (@(posedge clk) disable iff (!arst_n)
		st_reg == ST_GUARD |-> rx_reg)
		else $error("receivers off before guard");
	a_reset_out: assert property (@(posedge clk)
		!arst_n |-> !pd_act_reg && !pd_pre_reg)
		else $error("power-down held in reset");
	a_pd_flags: assert property (@(posedge clk) disable iff (!arst_n)
		st_reg == ST_GUARD || st_reg == ST_PD
		|-> pd_act_reg != pd_pre_reg)
		else $error("power-down kind flags inconsistent");
	a_nom_off: assert property (@(posedge clk) disable iff (!arst_n)
		st_reg == ST_PD && $stable(term_reg)
		&& term_reg[`DLPSC_TERM_BUF_BIT] |-> !nom_reg)
		else $error("nominal termination on in power-down");
	c_pd_active: cover property (@(posedge clk) disable iff (!arst_n)
		pd_act_reg && st_reg == ST_PD);
	c_pd_pre: cover property (@(posedge clk) disable iff (!arst_n)
		pd_pre_reg && st_reg == ST_PD);
	c_sr: cover property (@(posedge clk) disable iff (!arst_n) sr_reg);
endmodule // dlpsc_lp_ctrl

/* verification/dlpsc_ctrl_model.sv */
// Memory controller model driving the link pins of the device
module dlpsc_ctrl_model #(
	parameter int MIN_EDGES = 4
) (
	// Requested pin levels
	input wire logic want_cke,
	input wire logic want_cs_n,
	input wire logic want_odt,
	// Link pins
	output logic link_ck,
	output logic cke,
	output logic cs_n,
	output logic odt
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ck_q = 1'b0;
	logic cke_q = 1'b1;
	logic cs_n_q = 1'b1;
	logic odt_q = 1'b0;
	int held = MIN_EDGES;
	assign link_ck = ck_q;
	assign cke = cke_q;
	assign cs_n = cs_n_q;
	assign odt = odt_q;
	// Free-running memory clock, offset from the device clock
	initial begin
		#37;
		forever #200 ck_q = ~ck_q;
	end
	// Pins move on the falling edge so the device samples them settled
	always @(negedge ck_q) begin
		cs_n_q <= want_cs_n;
		odt_q <= want_odt;
		if (want_cke != cke_q && held >= MIN_EDGES) begin
			cke_q <= want_cke;
			held <= 0;
		end else begin
			held <= held + 1;
		end
	end
endmodule // dlpsc_ctrl_model

/* verification/tb_dlpsc_lp_ctrl.sv */
// Self-checking bench for the low-power state control block
`include "dlpsc_regs.svh"
module tb_dlpsc_lp_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {
		logic [1:0] range;
		logic hot;
		logic [2:0] rate;
		logic [6:0] lim;
	} dlpsc_row_t;
	logic clk = 1'b0;
	logic arst_n = 1'b1;
	logic [`DLPSC_ADDR_W-1:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic temp_hot = 1'b0;
	logic want_cke = 1'b1;
	logic want_cs_n = 1'b1;
	logic want_odt = 1'b1;
	logic [15:0] reg_rdata, d;
	logic link_ck, cke, cs_n, odt;
	logic pd_active, pd_precharge, self_refresh, cmd_rx_en;
	logic io_buf_en, odt_buf_en, nom_term_on, park_term_on;
	logic [2:0] sr_rate;
	int error_cnt = 0;
	int comparisons = 0;
	dlpsc_row_t rows [5] = '{
		'{2'b00, 1'b1, 3'h0, 7'h55},
		'{2'b01, 1'b0, 3'h1, 7'h2D},
		'{2'b10, 1'b1, 3'h2, 7'h5F},
		'{2'b11, 1'b0, 3'h3, 7'h00},
		'{2'b11, 1'b1, 3'h4, 7'h00}
	};
	always #25 clk = ~clk;
	dlpsc_ctrl_model model (.want_cke(want_cke), .want_cs_n(want_cs_n),
		.want_odt(want_odt), .link_ck(link_ck), .cke(cke), .cs_n(cs_n),
		.odt(odt));
	dlpsc_lp_ctrl dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .link_ck(link_ck), .cke(cke), .cs_n(cs_n),
		.odt(odt), .temp_hot(temp_hot), .pd_active(pd_active),
		.pd_precharge(pd_precharge), .self_refresh(self_refresh),
		.cmd_rx_en(cmd_rx_en), .io_buf_en(io_buf_en),
		.odt_buf_en(odt_buf_en), .nom_term_on(nom_term_on),
		.park_term_on(park_term_on), .sr_rate(sr_rate));
	task automatic results();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk_word(string nm, logic [15:0] exp, logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk_bit(string nm, logic exp, logic got);
		chk_word(nm, {15'h0000, exp}, {15'h0000, got});
	endtask
	function automatic logic [15:0] pick(int k);
		case (k)
			0: return {15'h0000, pd_active};
			1: return {15'h0000, pd_precharge};
			2: return {15'h0000, self_refresh};
			3: return {15'h0000, cmd_rx_en};
			default: return {13'h0000, sr_rate};
		endcase
	endfunction
	// Link traffic is slow and synchronised, so wait with a bound
	task automatic expect_on(string nm, int k, logic [15:0] v);
		int n;
		n = 0;
		@(negedge clk);
		while (pick(k) !== v && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk_word(nm, v, pick(k));
	endtask
	task automatic wr(logic [`DLPSC_ADDR_W-1:0] a, logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [`DLPSC_ADDR_W-1:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		results();
	end
	initial begin
		arst_n <= 1'b0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		chk_bit("rx_rst", 1'b1, cmd_rx_en);
		chk_bit("io_rst", 1'b1, io_buf_en);
		rd(`DLPSC_OFF_SRCFG);
		chk_word("srcfg_rst", `DLPSC_SRCFG_RST, d);
		rd(4'hF);
		chk_word("unmapped", 16'h0000, d);
		foreach (rows[i]) begin
			wr(`DLPSC_OFF_SRCFG, {8'h00, rows[i].range, 6'h00});
			temp_hot <= rows[i].hot;
			expect_on("sr_rate", 4, {13'h0000, rows[i].rate});
			rd(`DLPSC_OFF_STATUS);
			chk_word("st_rate", {13'h0000, rows[i].rate}, {13'h0000, d[6:4]});
			if (rows[i].range != 2'b11) begin
				chk_word("limit", {9'h000, rows[i].lim}, {9'h000, d[13:7]});
			end
		end
		// Precharge power-down, buffer kept, park on
		wr(`DLPSC_OFF_TERMCFG, 16'h0040);
		wr(`DLPSC_OFF_BANKS, 16'h0000);
		want_cke <= 1'b0;
		expect_on("pd_pre", 1, 16'h0001);
		chk_bit("rx_guard", 1'b1, cmd_rx_en);
		chk_bit("pd_act0", 1'b0, pd_active);
		expect_on("rx_off", 3, 16'h0000);
		chk_bit("io_off", 1'b0, io_buf_en);
		chk_bit("odt_buf", 1'b1, odt_buf_en);
		chk_bit("park_on", 1'b1, park_term_on);
		want_cke <= 1'b1;
		expect_on("pd_exit", 1, 16'h0000);
		expect_on("rx_back", 3, 16'h0001);
		chk_bit("io_back", 1'b1, io_buf_en);
		// Active power-down, buffer off, then reset inside it
		wr(`DLPSC_OFF_TERMCFG, 16'h0021);
		wr(`DLPSC_OFF_BANKS, 16'h0004);
		@(negedge clk);
		chk_bit("nom_on", 1'b1, nom_term_on);
		want_odt <= 1'b0;
		repeat (20) @(negedge clk);
		chk_bit("nom_odt_lo", 1'b0, nom_term_on);
		want_odt <= 1'b1;
		want_cke <= 1'b0;
		expect_on("pd_act", 0, 16'h0001);
		expect_on("rx_off2", 3, 16'h0000);
		chk_bit("odt_off", 1'b0, odt_buf_en);
		chk_bit("nom_off", 1'b0, nom_term_on);
		chk_bit("park_off", 1'b0, park_term_on);
		@(posedge clk);
		arst_n <= 1'b0;
		want_cke <= 1'b1;
		@(negedge clk);
		chk_bit("rst_pd", 1'b0, pd_active);
		chk_bit("rst_rx", 1'b1, cmd_rx_en);
		// Release once CKE is back high, else a stale low reads as entry
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		// Self-refresh with a refused range change, exit by deselect
		wr(`DLPSC_OFF_SRCFG, 16'h0080);
		wr(`DLPSC_OFF_CTRL, 16'h0001);
		want_cs_n <= 1'b0;
		want_cke <= 1'b0;
		expect_on("sr_in", 2, 16'h0001);
		want_cs_n <= 1'b1;
		wr(`DLPSC_OFF_SRCFG, 16'h0040);
		rd(`DLPSC_OFF_SRCFG);
		chk_word("sr_lock", 16'h0080, d);
		want_cke <= 1'b1;
		expect_on("sr_out", 2, 16'h0000);
		results();
	end
endmodule // tb_dlpsc_lp_ctrl
